// File: uhet_pkg.sv
package uhet_pkg;

  // ----------------------------------------------------------------
  // timing figures, as printed, and derived clock counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PS = 5000;
  // short SE0 filter, ns
  localparam int unsigned SE0_FILT_NS = 2500;
  localparam int unsigned SE0_FILT_CYC = (SE0_FILT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // full-speed chirp start point, us (inside 2.5 us .. 3000 us)
  localparam int unsigned FS_CHIRP_US = 2500;
  // high-speed revert, us: 3.0 ms min, 3.125 ms max
  localparam int unsigned HS_REV_MIN_US = 3000;
  localparam int unsigned HS_REV_MAX_US = 3125;
  localparam int unsigned HS_REV_US = 3050;
  // settle after fallback (100 .. 875), us
  localparam int unsigned FALLBACK_US = 100;
  // chirp K length, us (>= 1.0 ms, must end before 7.0 ms from SE0)
  localparam int unsigned CHIRP_K_US = 1500;
  localparam int unsigned CHIRP_END_MAX_US = 7000;
  // returning chirp to high-speed, us (<= 500)
  localparam int unsigned TO_HS_US = 400;
  // no returning chirp to full-speed, us (1.0 .. 2.5 ms)
  localparam int unsigned NO_CHIRP_US = 2000;
  // reset recovery, us (<= 10 ms)
  localparam int unsigned RECOVERY_US = 8000;
  // control request limits, us
  localparam int unsigned REQ_NODATA_US = 50000;
  localparam int unsigned REQ_DATA_US = 500000;
  localparam int unsigned REQ_LAST_US = 50000;
  // full-speed bit time, ps (12 Mb/s)
  localparam int unsigned FS_BIT_PS = 83333;
  localparam int unsigned IPD_MIN_CYC = (2 * FS_BIT_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RSP_MAX_CYC = (13 * FS_BIT_PS / 2) / CLK_PS;

  localparam int unsigned US_CYC = CLK_MHZ;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UHET_REQ_NONE,
    UHET_REQ_NODATA,
    UHET_REQ_DATA,
    UHET_REQ_LAST
  } uhet_req_type;

  typedef struct packed {
    logic se0;
    logic chirp_back;
    logic suspended;
    logic hs_capable;
  } uhet_line_type;

  typedef struct packed {
    logic high_speed;
    logic chirp_k;
    logic bus_reset;
    logic ready;
  } uhet_link_type;

endpackage : uhet_pkg

// File: uhet_timers.sv
// Operation
// - high-speed SE0 3.0-3.125 ms reverts to full-speed
// - awake full-speed chirp starts 2.5 us-3000 us
// - suspended hub needs 2.5 us SE0 first
// - wait 100-875 after fallback before chirp
// - upstream chirp K lasts at least 1.0 ms
// - chirp K over within 7.0 ms of SE0
// - returning chirp gives high-speed within 500 us
// - no returning chirp: full-speed in 1.0-2.5 ms
// - non-HS hub detects reset in 2.5-10000 us
// - ready for traffic within 10 ms of reset
// - full-speed gap at least 2, reply within 6.5
// - no-data request done within 50 ms
// - non-final data packet within 500 ms
// - final data packet within 50 ms
module uhet_timers #(
  parameter int unsigned US_CYC = uhet_pkg::US_CYC,
  parameter int unsigned FS_CHIRP_US = uhet_pkg::FS_CHIRP_US,
  parameter int unsigned HS_REV_US = uhet_pkg::HS_REV_US,
  parameter int unsigned FALLBACK_US = uhet_pkg::FALLBACK_US,
  parameter int unsigned CHIRP_K_US = uhet_pkg::CHIRP_K_US,
  parameter int unsigned TO_HS_US = uhet_pkg::TO_HS_US,
  parameter int unsigned NO_CHIRP_US = uhet_pkg::NO_CHIRP_US,
  parameter int unsigned RECOVERY_US = uhet_pkg::RECOVERY_US,
  parameter int unsigned REQ_NODATA_US = uhet_pkg::REQ_NODATA_US,
  parameter int unsigned REQ_DATA_US = uhet_pkg::REQ_DATA_US,
  parameter int unsigned REQ_LAST_US = uhet_pkg::REQ_LAST_US
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire uhet_pkg::uhet_line_type line_i,
  input wire logic rx_eop_i,
  input wire logic tx_start_i,
  input wire uhet_pkg::uhet_req_type req_i,
  input wire logic req_done_i,
  output uhet_pkg::uhet_link_type link_o,
  output logic tx_allow_o,
  output logic rsp_late_o,
  output logic req_late_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  uhet_pkg::uhet_line_type line_m_q, line_s_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_m_q <= '0;
      line_s_q <= '0;
    end else begin
      line_m_q <= line_i;
      line_s_q <= line_m_q;
    end
  end

  // ----------------------------------------------------------------
  // microsecond tick and SE0 length
  // ----------------------------------------------------------------
  logic [15:0] pre_q;
  logic [31:0] se0_us_q, st_us_q;
  logic [15:0] se0_f_q;
  wire tick = (pre_q == 16'(US_CYC - 1));
  wire se0 = line_s_q.se0;
  // filtered SE0: unbroken for the short filter time
  wire se0_filt = (se0_f_q >= 16'(uhet_pkg::SE0_FILT_CYC));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= 16'H0000;
      se0_f_q <= 16'H0000;
    end else begin
      pre_q <= tick ? 16'H0000 : pre_q + 16'H0001;
      se0_f_q <= !se0 ? 16'H0000 : (se0_filt ? se0_f_q : se0_f_q + 16'H0001);
    end
  end

  // ----------------------------------------------------------------
  // reset / chirp state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_FS, S_HS, S_SETTLE, S_CHIRP, S_WAIT_BACK, S_GO_HS, S_RECOVER
  } uhet_state_type;
  uhet_state_type st_q, st_d;
  logic [31:0] chirp_start_q;

  // awake full-speed hub chirps at a fixed point in its window
  wire fs_reset = se0_filt && line_s_q.hs_capable && (se0_us_q >= FS_CHIRP_US);
  // non high-speed capable hub takes the filtered SE0 as reset
  wire fs_plain = se0_filt && !line_s_q.hs_capable;
  // suspended hub starts as soon as the filter passes
  wire susp_go = se0_filt && line_s_q.suspended && line_s_q.hs_capable;
  // high-speed idle SE0 past the revert point
  wire hs_rev = se0 && (se0_us_q >= HS_REV_US);

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_FS: begin
        if (susp_go || fs_reset) st_d = S_CHIRP;
        else if (fs_plain) st_d = S_RECOVER;
      end
      S_HS: if (hs_rev) st_d = S_SETTLE;
      S_SETTLE: if (st_us_q >= FALLBACK_US) st_d = se0 ? S_CHIRP : S_RECOVER;
      S_CHIRP: if (st_us_q >= CHIRP_K_US) st_d = S_WAIT_BACK;
      S_WAIT_BACK: begin
        if (line_s_q.chirp_back) st_d = S_GO_HS;
        else if (st_us_q >= NO_CHIRP_US) st_d = S_RECOVER;
      end
      S_GO_HS: if (st_us_q >= TO_HS_US || !se0) st_d = S_HS;
      S_RECOVER: if (!se0 && st_us_q >= RECOVERY_US) st_d = S_FS;
      default: st_d = S_FS;
    endcase
  end

  // state and its time base; time restarts on every state change
  // recovery is timed from the end of SE0, so it restarts while SE0 lasts
  wire st_restart = (st_d != st_q) || (st_q == S_RECOVER && se0);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= S_FS;
      st_us_q <= 32'H0000_0000;
    end else begin
      st_q <= st_d;
      st_us_q <= st_restart ? 32'H0000_0000 : st_us_q + {31'H0, tick};
    end
  end

  // se0 age; restarts on high-speed entry, else the tail of the reset
  // itself would look like an idle SE0 and revert at once
  wire hs_entry = (st_d == S_HS) && (st_q != S_HS);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      se0_us_q <= 32'H0000_0000;
    end else begin
      se0_us_q <= (!se0 || hs_entry) ? 32'H0000_0000 : se0_us_q + {31'H0, tick};
    end
  end

  // se0 age at chirp start, kept for the chirp end limit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chirp_start_q <= 32'H0000_0000;
    end else if (st_d == S_CHIRP && st_q != S_CHIRP) begin
      chirp_start_q <= se0_us_q;
    end
  end

  // registered link outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_o <= '0;
    end else begin
      link_o.high_speed <= (st_d == S_HS);
      link_o.chirp_k <= (st_d == S_CHIRP);
      link_o.bus_reset <= (st_d != S_FS) && (st_d != S_HS);
      link_o.ready <= (st_d == S_FS) || (st_d == S_HS);
    end
  end

  // ----------------------------------------------------------------
  // full-speed packet gap and response timing
  // ----------------------------------------------------------------
  logic [7:0] gap_q;
  logic rsp_wait_q;
  wire gap_ok = (gap_q >= 8'(uhet_pkg::IPD_MIN_CYC));
  // count runs on to the reply limit, so one counter serves both checks
  wire gap_full = (gap_q >= 8'(uhet_pkg::RSP_MAX_CYC));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_q <= 8'H00;
      rsp_wait_q <= 1'b0;
      tx_allow_o <= 1'b0;
      rsp_late_o <= 1'b0;
    end else begin
      gap_q <= rx_eop_i ? 8'H00 : (gap_full ? gap_q : gap_q + 8'H01);
      rsp_wait_q <= rx_eop_i ? 1'b1 : (tx_start_i ? 1'b0 : rsp_wait_q);
      // transmit only after the least gap
      tx_allow_o <= !rx_eop_i && (gap_ok || gap_q == 8'(uhet_pkg::IPD_MIN_CYC - 1));
      // answer must start inside 6.5 bit times, else flagged
      rsp_late_o <= rsp_wait_q && !tx_start_i && (gap_q >= 8'(uhet_pkg::RSP_MAX_CYC));
    end
  end

  // ----------------------------------------------------------------
  // control request watchdog
  // ----------------------------------------------------------------
  logic [31:0] req_us_q, req_lim_q;
  logic req_run_q;
  // limit chosen by request kind
  wire [31:0] req_lim = (req_i == uhet_pkg::UHET_REQ_DATA) ? REQ_DATA_US :
                        (req_i == uhet_pkg::UHET_REQ_LAST) ? REQ_LAST_US : REQ_NODATA_US;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_us_q <= 32'H0000_0000;
      req_lim_q <= 32'H0000_0000;
      req_run_q <= 1'b0;
      req_late_o <= 1'b0;
    end else begin
      if (req_i != uhet_pkg::UHET_REQ_NONE) begin
        req_run_q <= 1'b1;
        req_us_q <= 32'H0000_0000;
        req_lim_q <= req_lim;
      end else if (req_done_i) begin
        req_run_q <= 1'b0;
      end else begin
        req_us_q <= req_us_q + {31'H0, tick & req_run_q};
      end
      req_late_o <= req_run_q && !req_done_i && (req_us_q >= req_lim_q);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence chirp_begin_s;
    $rose(link_o.chirp_k);
  endsequence

  hs_revert_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_HS && st_d == S_SETTLE) |-> (se0_us_q >= 32'(uhet_pkg::HS_REV_MIN_US)
      && se0_us_q < 32'(uhet_pkg::HS_REV_MAX_US)))
    else $error("high-speed revert outside window");
  susp_filter_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_FS && st_d == S_CHIRP) |-> se0_filt)
    else $error("chirp began before SE0 filter");
  settle_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_SETTLE && st_d != S_SETTLE) |-> st_us_q >= FALLBACK_US)
    else $error("fallback settle too short");
  chirp_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_CHIRP && st_d != S_CHIRP) |-> st_us_q >= CHIRP_K_US)
    else $error("chirp K too short");
  chirp_end_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_CHIRP) |-> (chirp_start_q + st_us_q) < 32'(uhet_pkg::CHIRP_END_MAX_US))
    else $error("chirp K ended too late");
  go_hs_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_GO_HS) |-> st_us_q <= TO_HS_US)
    else $error("high-speed entry too late");
  no_back_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == S_WAIT_BACK && st_d == S_RECOVER) |-> st_us_q >= NO_CHIRP_US)
    else $error("full-speed fallback too early");
  chirp_out_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    chirp_begin_s |-> link_o.bus_reset && !link_o.ready)
    else $error("chirp K without reset state");
  gap_min_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_eop_i |=> !tx_allow_o)
    else $error("transmit allowed inside packet gap");
  req_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (req_run_q && !req_done_i && req_i == uhet_pkg::UHET_REQ_NONE
      && req_us_q >= req_lim_q) |=> req_late_o)
    else $error("request overrun not flagged");

endmodule // uhet_timers

// File: uhet_host_model.sv
module uhet_host_model (
  input wire logic clk_i,
  input wire logic se0_i,
  input wire logic answer_i,
  input wire logic suspend_i,
  input wire logic hs_cap_i,
  input wire uhet_pkg::uhet_link_type link_i,
  output uhet_pkg::uhet_line_type line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q;
  logic [3:0] dly_q;
  // ----------------------------------------------------------------
  // returning chirp, only after the hub's own chirp k has ended
  // ----------------------------------------------------------------
  // host waits a few cycles, like a real host turning the line round
  always_ff @(posedge clk_i) begin
    if (!se0_i) begin
      seen_q <= 1'b0;
      dly_q <= 4'h0;
    end else if (link_i.chirp_k) begin
      seen_q <= 1'b1;
    end else if (seen_q && dly_q != 4'hF) begin
      dly_q <= dly_q + 4'h1;
    end
  end
  // chirp stops with se0, as the host ends reset
  wire back = se0_i & answer_i & seen_q & (dly_q > 4'h7);
  assign line_o = '{se0: se0_i, chirp_back: back, suspended: suspend_i, hs_capable: hs_cap_i};
endmodule // uhet_host_model

// File: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int US = 2;
  localparam int FSC = 400;
  localparam int REV = uhet_pkg::HS_REV_US;
  localparam int FB = 20;
  localparam int CK = 200;
  localparam int THS = 50;
  localparam int NOC = 150;
  localparam int REC = 300;
  localparam int RQN = 100;
  localparam int RQD = 300;
  localparam int RQL = 120;
  localparam int FILT = uhet_pkg::SE0_FILT_CYC;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic se0 = 1'b0, answer = 1'b0, suspend = 1'b0, hs_cap = 1'b1;
  logic rx_eop_i = 1'b0, tx_start_i = 1'b0, req_done_i = 1'b0;
  uhet_pkg::uhet_req_type req_i = uhet_pkg::UHET_REQ_NONE;
  uhet_pkg::uhet_line_type line_i;
  uhet_pkg::uhet_link_type link_o;
  logic tx_allow_o, rsp_late_o, req_late_o;
  wire [6:0] obs = {link_o, tx_allow_o, rsp_late_o, req_late_o};
  int n_fail = 0;
  int comparisons = 0;
  int n;
  typedef struct {uhet_pkg::uhet_req_type req; int lim;} uhet_row_type;
  uhet_row_type rows [3] = '{'{uhet_pkg::UHET_REQ_NODATA, RQN * US},
    '{uhet_pkg::UHET_REQ_DATA, RQD * US}, '{uhet_pkg::UHET_REQ_LAST, RQL * US}};
  always #2.5 clk_i = ~clk_i;
  uhet_host_model uhet_host_model_i (.clk_i(clk_i), .se0_i(se0), .answer_i(answer),
    .suspend_i(suspend), .hs_cap_i(hs_cap), .link_i(link_o), .line_o(line_i));
  uhet_timers #(.US_CYC(US), .FS_CHIRP_US(FSC), .HS_REV_US(REV), .FALLBACK_US(FB),
    .CHIRP_K_US(CK), .TO_HS_US(THS), .NO_CHIRP_US(NOC), .RECOVERY_US(REC),
    .REQ_NODATA_US(RQN), .REQ_DATA_US(RQD), .REQ_LAST_US(RQL)) uhet_timers_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .line_i(line_i), .rx_eop_i(rx_eop_i),
    .tx_start_i(tx_start_i), .req_i(req_i), .req_done_i(req_done_i), .link_o(link_o),
    .tx_allow_o(tx_allow_o), .rsp_late_o(rsp_late_o), .req_late_o(req_late_o));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // inputs always move 1 ns after the edge, never on it
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // bounded wait: a stuck output ends the wait at lim, and rng flags it
  task automatic wait_obs(int idx, logic v, int lim);
    n = 0;
    while (obs[idx] !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  task automatic rng(int lo, int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("unexpected at %0t: count %0h outside %0h..%0h", $time, n, lo, hi);
    end
  endtask
  task automatic do_reset();
    nrst_i = 1'b0;
    se0 = 1'b0;
    tick(4);
    nrst_i = 1'b1;
    tick();
  endtask
  task automatic results();
    $display("failures %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #(60000 * 5);
    n_fail++;
    results();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    chk(link_o, 4'h1);
    // request watchdogs, one row per request kind
    foreach (rows[i]) begin
      req_i = rows[i].req;
      tick();
      req_i = uhet_pkg::UHET_REQ_NONE;
      tick(rows[i].lim - 4);
      chk(req_late_o, 1'b0);
      wait_obs(0, 1'b1, 12);
      rng(0, 10);
      req_done_i = 1'b1;
      tick();
      req_done_i = 1'b0;
      tick(2);
      chk(req_late_o, 1'b0);
    end
    // full-speed gaps: answered reply first, then a late one
    rx_eop_i = 1'b1;
    tick();
    rx_eop_i = 1'b0;
    tick();
    chk(tx_allow_o, 1'b0);
    wait_obs(2, 1'b1, 60);
    rng(uhet_pkg::IPD_MIN_CYC - 4, uhet_pkg::IPD_MIN_CYC + 2);
    tx_start_i = 1'b1;
    tick();
    tx_start_i = 1'b0;
    tick(uhet_pkg::RSP_MAX_CYC);
    chk(rsp_late_o, 1'b0);
    rx_eop_i = 1'b1;
    tick();
    rx_eop_i = 1'b0;
    wait_obs(1, 1'b1, 140);
    rng(uhet_pkg::RSP_MAX_CYC - 3, uhet_pkg::RSP_MAX_CYC + 3);
    // high-speed handshake, then revert and a chirp the host ignores
    do_reset();
    chk(obs, 7'H08);
    answer = 1'b1;
    se0 = 1'b1;
    wait_obs(5, 1'b1, FSC * US + 20);
    rng(FSC * US - 2, FSC * US + 8);
    wait_obs(5, 1'b0, CK * US + 20);
    rng(CK * US - 1, CK * US + 4);
    wait_obs(6, 1'b1, THS * US + 40);
    rng(0, THS * US + 14);
    se0 = 1'b0;
    tick(20);
    chk(link_o.high_speed, 1'b1);
    answer = 1'b0;
    se0 = 1'b1;
    wait_obs(6, 1'b0, REV * US + 20);
    rng(REV * US - 4, REV * US + 8);
    wait_obs(5, 1'b1, FB * US + 20);
    rng(FB * US - 2, FB * US + 8);
    wait_obs(5, 1'b0, CK * US + 20);
    tick(NOC * US + 10);
    chk(link_o.high_speed, 1'b0);
    chk(link_o, 4'H2);
    se0 = 1'b0;
    tick();
    wait_obs(3, 1'b1, REC * US + 40);
    rng(REC * US - 4, REC * US + 12);
    // hub without high-speed: plain reset detection
    do_reset();
    hs_cap = 1'b0;
    se0 = 1'b1;
    wait_obs(4, 1'b1, FILT + 40);
    rng(FILT - 2, FILT + 10);
    tick(FSC * US);
    chk(link_o.chirp_k, 1'b0);
    se0 = 1'b0;
    wait_obs(3, 1'b1, REC * US + 40);
    rng(REC * US - 4, REC * US + 12);
    // suspended hub chirps once the se0 filter has passed
    do_reset();
    hs_cap = 1'b1;
    suspend = 1'b1;
    se0 = 1'b1;
    wait_obs(5, 1'b1, FILT + 40);
    rng(FILT - 2, FILT + 10);
    results();
  end
endmodule // tb
